// ---- logic/cycle_steal_pkg.sv ----
// Shared constants for the channel cycle-steal multiplexor and its channels.
// Assumes one system clock; the channel pulse clock is made by the channel end.
package cycle_steal_pkg;
   // ****************************************************************
   // Widths and word fields
   // ****************************************************************
   localparam int WORD_W       = 36;
   localparam int ADDR_W       = 15;
   localparam int NCH_DEF      = 4;
   // Word bit n (0 = high end) sits at vector index WORD_W-1-n
   localparam int IND_BIT      = 17;   // Word bit 18
   localparam int ADDR_LO      = 0;    // Word bits 21-35
   localparam int ADDR_HI      = 14;
   localparam int OP_HI        = 35;   // Word bits 0-2
   localparam int OP_LO        = 33;
   localparam int OP_WRITE_BIT = 35;   // Op bit 0: channel writes a device
   localparam int WC_HI        = 32;   // Word bits 3-17
   localparam int WC_LO        = 18;
   localparam int EO_BIT       = 0;    // Address bit 17, even/odd choice
   // ****************************************************************
   // Channel and processor pulse times
   // ****************************************************************
   localparam logic [3:0] CH_PULSES   = 4'hc;
   localparam logic [3:0] T_DEMAND    = 4'h3;
   localparam logic [3:0] T_SET       = 4'h9;
   localparam logic [3:0] T_FOLLOW_CLR = 4'ha;
   localparam logic [3:0] T_BAR_CLR   = 4'hb;
   localparam logic [3:0] T_BAR_LOAD  = 4'h0;
   localparam logic [3:0] T_SELECT    = 4'h2;
   localparam logic [3:0] T_CTL_CLR   = 4'h3;
   localparam logic [3:0] T_SAMPLE    = 4'h7;
   localparam logic [2:0] CPU_LAST    = 3'h7;
   localparam logic [2:0] CPU_BLOCK_T = 3'h5;
   // ****************************************************************
   // Clock rates
   // ****************************************************************
   localparam int CLK_PERIOD_NS  = 10;
   localparam int CHAN_PULSE_NS  = 160;
   localparam int CHAN_HALF_CYC  = CHAN_PULSE_NS / (2 * CLK_PERIOD_NS);
endpackage : cycle_steal_pkg

// ---- logic/cycle_steal_if.sv ----
// Link between the multiplexor and its data channels.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface cycle_steal_if #(parameter int NCH = 4) ();
   import cycle_steal_pkg::*;
   logic              chan_clk;
   logic [3:0]        chan_time;
   logic [NCH-1:0]    demand;
   logic              chan_cmd;
   logic              chan_read;
   logic [ADDR_W-1:0] chan_addr;
   logic [WORD_W-1:0] chan_wdata;
   logic [NCH-1:0]    grant;
   logic              buffer_time;
   logic              store_trig;
   logic              retain_priority;
   logic              indirect_follow_flag;
   logic [WORD_W-1:0] sb_data;
   logic              sb_strobe;

   modport mux (input chan_clk, chan_time, demand, chan_cmd, chan_read,
                chan_addr, chan_wdata,
                output grant, buffer_time, store_trig, retain_priority,
                indirect_follow_flag, sb_data, sb_strobe);
   modport chan (output chan_clk, chan_time, demand, chan_cmd, chan_read,
                 chan_addr, chan_wdata,
                 input grant, buffer_time, store_trig, retain_priority,
                 indirect_follow_flag, sb_data, sb_strobe);
endinterface : cycle_steal_if

// ---- logic/steal_mux.sv ----
// Multiplexor end: grants channels buffer cycles on core storage and
// blocks processor cycle outputs while they run.
// Assumes the channel pulse clock and time code come in from the link.
`timescale 1ns/1ps
module steal_mux
   import cycle_steal_pkg::*;
#(
   parameter int NCH = NCH_DEF
) (
   input  wire logic              CLK,
   input  wire logic              RESET,
   cycle_steal_if.mux             ch,
   input  wire logic              I_REQ,
   input  wire logic              E_REQ,
   input  wire logic              O_REQ,
   input  wire logic              MASTER_STOP,
   input  wire logic              TRAP_BUSY,
   input  wire logic              STORE_CHAN_BUSY,
   input  wire logic [WORD_W-1:0] MEM_RDATA_EVEN,
   input  wire logic [WORD_W-1:0] MEM_RDATA_ODD,
   output logic                   I_CYC,
   output logic                   E_CYC,
   output logic                   O_CYC,
   output logic                   BLOCKING,
   output logic                   OVERLAP_SUSPEND,
   output logic                   MEM_SEL_EVEN,
   output logic                   MEM_SEL_ODD,
   output logic                   MEM_WRITE,
   output logic [ADDR_W-2:0]      MEM_ADDR,
   output logic [WORD_W-1:0]      MEM_WDATA
);
   // ****************************************************************
   // Link sampling
   // ****************************************************************
   logic              clk_s1_q, clk_s2_q, clk_s3_q;
   logic [3:0]        time_s1_q, time_s2_q;
   logic              pulse;
   logic [2:0]        cpu_t_q;
   logic              bt_q, bt_d;
   logic              blk_q, blk_d;
   logic              ctl_q, follow_q, cmd_q, read_q;
   logic [NCH-1:0]    grant_q, pick;
   logic [ADDR_W-1:0] bar_q;
   logic [WORD_W-1:0] bus;
   logic              gate_ok;
   logic              ind_seen;

   // Time code is delayed alongside the clock so both match at the edge
   always_ff @(posedge CLK) begin
      if (RESET) begin
         clk_s1_q  <= 1'b0;
         clk_s2_q  <= 1'b0;
         clk_s3_q  <= 1'b0;
         time_s1_q <= 4'h0;
         time_s2_q <= 4'h0;
      end else begin
         clk_s1_q  <= ch.chan_clk;
         clk_s2_q  <= clk_s1_q;
         clk_s3_q  <= clk_s2_q;
         time_s1_q <= ch.chan_time;
         time_s2_q <= time_s1_q;
      end
   end

   assign pulse = clk_s2_q & ~clk_s3_q;

   // Processor pulses: one per system clock, eight to a cycle
   always_ff @(posedge CLK) begin
      if (RESET) begin
         cpu_t_q <= 3'h0;
      end else if (cpu_t_q == CPU_LAST) begin
         cpu_t_q <= 3'h0;
      end else begin
         cpu_t_q <= cpu_t_q + 3'h1;
      end
   end

   // ****************************************************************
   // Buffer time and grant
   // ****************************************************************
   always_comb begin
      pick = '0;
      for (int i = NCH - 1; i >= 0; i--) begin
         if (ch.demand[i]) begin
            pick = '0;
            pick[i] = 1'b1;
         end
      end
   end

   assign gate_ok = (|ch.demand) & ~TRAP_BUSY & ~STORE_CHAN_BUSY;

   always_comb begin
      bt_d = bt_q;
      if (pulse && time_s2_q == T_SET) begin
         // Re-set on the same pulse keeps cycles back to back
         bt_d = ctl_q | gate_ok;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         bt_q    <= 1'b0;
         grant_q <= '0;
         cmd_q   <= 1'b0;
         read_q  <= 1'b0;
      end else begin
         bt_q <= bt_d;
         if (pulse && time_s2_q == T_SET) begin
            if (!bt_d) begin
               grant_q <= '0;
            end else if (!ctl_q) begin
               grant_q <= pick;
               cmd_q   <= ch.chan_cmd;
               read_q  <= ch.chan_read & ~ch.chan_cmd;
            end
         end
      end
   end

   // ****************************************************************
   // Processor blocking
   // ****************************************************************
   // Using the next buffer time lets both triggers set on one pulse
   always_comb begin
      blk_d = blk_q;
      if (cpu_t_q == CPU_BLOCK_T) begin
         blk_d = bt_d | MASTER_STOP;
      end else if (MASTER_STOP) begin
         blk_d = 1'b1;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         blk_q           <= 1'b0;
         I_CYC           <= 1'b0;
         E_CYC           <= 1'b0;
         O_CYC           <= 1'b0;
         OVERLAP_SUSPEND <= 1'b0;
      end else begin
         blk_q           <= blk_d;
         I_CYC           <= I_REQ & ~blk_d;
         E_CYC           <= E_REQ & ~blk_d;
         O_CYC           <= O_REQ & ~blk_d & ~bt_d;
         OVERLAP_SUSPEND <= bt_d;
      end
   end

   assign BLOCKING = blk_q;

   // ****************************************************************
   // Buffer address and memory select
   // ****************************************************************
   assign bus = MEM_RDATA_EVEN | MEM_RDATA_ODD;

   assign ind_seen = pulse && time_s2_q == T_SAMPLE && bt_q && cmd_q
                     && !follow_q && bus[IND_BIT];

   always_ff @(posedge CLK) begin
      if (RESET) begin
         bar_q <= '0;
      end else if (ind_seen) begin
         bar_q <= bus[ADDR_HI:ADDR_LO];
      end else if (pulse && time_s2_q == T_BAR_CLR && !follow_q) begin
         bar_q <= '0;
      end else if (pulse && time_s2_q == T_BAR_LOAD && bt_q && !follow_q) begin
         bar_q <= ch.chan_addr;
      end
   end

   // One select pulse on one memory per buffer cycle
   always_ff @(posedge CLK) begin
      if (RESET) begin
         MEM_SEL_EVEN <= 1'b0;
         MEM_SEL_ODD  <= 1'b0;
         MEM_WRITE    <= 1'b0;
         MEM_ADDR     <= '0;
         MEM_WDATA    <= '0;
      end else if (pulse && time_s2_q == T_SELECT && bt_q) begin
         MEM_SEL_EVEN <= ~bar_q[EO_BIT];
         MEM_SEL_ODD  <= bar_q[EO_BIT];
         MEM_WRITE    <= read_q;
         MEM_ADDR     <= bar_q[ADDR_W-1:1];
         MEM_WDATA    <= ch.chan_wdata;
      end else begin
         MEM_SEL_EVEN <= 1'b0;
         MEM_SEL_ODD  <= 1'b0;
         MEM_WRITE    <= 1'b0;
      end
   end

   // ****************************************************************
   // Storage bus to the channels and indirect control
   // ****************************************************************
   always_ff @(posedge CLK) begin
      if (RESET) begin
         ch.sb_data   <= '0;
         ch.sb_strobe <= 1'b0;
      end else begin
         ch.sb_strobe <= pulse && time_s2_q == T_SAMPLE && bt_q;
         if (pulse && time_s2_q == T_SAMPLE && bt_q) begin
            ch.sb_data <= read_q ? ch.chan_wdata : bus;
         end
      end
   end

   // Control set at B7 and cleared at A3 never meet on one pulse
   always_ff @(posedge CLK) begin
      if (RESET) begin
         ctl_q <= 1'b0;
      end else if (ind_seen) begin
         ctl_q <= 1'b1;
      end else if (pulse && time_s2_q == T_CTL_CLR) begin
         ctl_q <= 1'b0;
      end
   end

   // While follow is set a second indirect bit is ignored
   always_ff @(posedge CLK) begin
      if (RESET) begin
         follow_q <= 1'b0;
      end else if (ctl_q) begin
         follow_q <= 1'b1;
      end else if (pulse && time_s2_q == T_FOLLOW_CLR) begin
         follow_q <= 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         ch.store_trig <= 1'b0;
      end else begin
         ch.store_trig <= bt_d && (pulse && time_s2_q == T_SET ?
                          (ctl_q ? read_q : ch.chan_read & ~ch.chan_cmd)
                          : read_q);
      end
   end

   assign ch.grant                = grant_q;
   assign ch.buffer_time          = bt_q;
   assign ch.retain_priority      = ctl_q;
   assign ch.indirect_follow_flag = follow_q;
endmodule : steal_mux

// ---- logic/steal_chan.sv ----
// Channel end: makes the channel pulse clock and time code, raises
// demands and takes commands and data from the storage bus.
// Assumes the multiplexor answers over the same interface and clock.
`timescale 1ns/1ps
module steal_chan
   import cycle_steal_pkg::*;
#(
   parameter int NCH  = NCH_DEF,
   parameter int CH   = 0,
   parameter int HALF = CHAN_HALF_CYC
) (
   input  wire logic              CLK,
   input  wire logic              RESET,
   cycle_steal_if.chan            ch,
   input  wire logic              DATA_REQ,
   input  wire logic              CMD_REQ,
   input  wire logic              READ_MODE,
   input  wire logic [WORD_W-1:0] CH_WDATA,
   input  wire logic [NCH-1:0]    OTHER_DEMAND,
   output logic [OP_HI-OP_LO:0]   OP_REG,
   output logic [WC_HI-WC_LO:0]   WORD_COUNT,
   output logic [ADDR_W-1:0]      ADDR_REG,
   output logic [ADDR_W-1:0]      LOC_COUNT,
   output logic [WORD_W-1:0]      DATA_REG,
   output logic                   DATA_DONE
);
   // ****************************************************************
   // Pulse clock
   // ****************************************************************
   logic [7:0] div_q;
   logic       rise;
   logic       pend_data_q, pend_cmd_q, dem_q, mine;
   logic       wr_op;

   assign rise = (div_q == 8'(HALF - 1)) && !ch.chan_clk;

   // Time advances on the falling edge so it is steady at the rise
   always_ff @(posedge CLK) begin
      if (RESET) begin
         div_q        <= 8'h0;
         ch.chan_clk  <= 1'b0;
         ch.chan_time <= 4'h0;
      end else if (div_q == 8'(HALF - 1)) begin
         div_q       <= 8'h0;
         ch.chan_clk <= ~ch.chan_clk;
         if (ch.chan_clk) begin
            ch.chan_time <= (ch.chan_time == CH_PULSES - 4'h1) ?
                            4'h0 : ch.chan_time + 4'h1;
         end
      end else begin
         div_q <= div_q + 8'h1;
      end
   end

   // ****************************************************************
   // Requests and demand
   // ****************************************************************
   assign mine  = ch.sb_strobe & ch.grant[CH];
   assign wr_op = ch.indirect_follow_flag ? OP_REG[OP_HI-OP_LO]
                                          : ch.sb_data[OP_WRITE_BIT];

   // A new request beside a completed cycle is kept: set wins
   always_ff @(posedge CLK) begin
      if (RESET) begin
         pend_data_q <= 1'b0;
         pend_cmd_q  <= 1'b0;
      end else begin
         if (DATA_REQ || (mine && pend_cmd_q && wr_op
                          && !(ch.sb_data[IND_BIT]
                               && !ch.indirect_follow_flag))) begin
            pend_data_q <= 1'b1;
         end else if (mine && !pend_cmd_q) begin
            pend_data_q <= 1'b0;
         end
         if (CMD_REQ) begin
            pend_cmd_q <= 1'b1;
         end else if (mine && (ch.indirect_follow_flag
                               || !ch.sb_data[IND_BIT])) begin
            pend_cmd_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         dem_q         <= 1'b0;
         ch.chan_cmd   <= 1'b0;
         ch.chan_read  <= 1'b0;
         ch.chan_addr  <= '0;
         ch.chan_wdata <= '0;
      end else begin
         if (mine || ch.grant[CH]) begin
            dem_q <= 1'b0;
         end else if (rise && ch.chan_time == T_DEMAND) begin
            dem_q <= pend_data_q | pend_cmd_q;
         end
         ch.chan_cmd   <= pend_cmd_q;
         ch.chan_read  <= READ_MODE & ~pend_cmd_q;
         ch.chan_addr  <= pend_cmd_q ? LOC_COUNT : ADDR_REG;
         ch.chan_wdata <= CH_WDATA;
      end
   end

   always_comb begin
      ch.demand     = OTHER_DEMAND;
      ch.demand[CH] = dem_q;
   end

   // ****************************************************************
   // Command and data registers
   // ****************************************************************
   always_ff @(posedge CLK) begin
      if (RESET) begin
         OP_REG     <= '0;
         WORD_COUNT <= '0;
         ADDR_REG   <= '0;
         LOC_COUNT  <= '0;
         DATA_REG   <= '0;
         DATA_DONE  <= 1'b0;
      end else begin
         DATA_DONE <= mine && !pend_cmd_q;
         if (mine && pend_cmd_q) begin
            if (ch.indirect_follow_flag) begin
               ADDR_REG  <= ch.sb_data[ADDR_HI:ADDR_LO];
               LOC_COUNT <= LOC_COUNT + 15'h1;
            end else begin
               OP_REG     <= ch.sb_data[OP_HI:OP_LO];
               WORD_COUNT <= ch.sb_data[WC_HI:WC_LO];
               ADDR_REG   <= ch.sb_data[ADDR_HI:ADDR_LO];
               if (!ch.sb_data[IND_BIT]) begin
                  LOC_COUNT <= LOC_COUNT + 15'h1;
               end
            end
         end else if (mine) begin
            if (!READ_MODE) begin
               DATA_REG <= ch.sb_data;
            end
            ADDR_REG   <= ADDR_REG + 15'h1;
            WORD_COUNT <= WORD_COUNT - 15'h1;
         end
      end
   end
endmodule : steal_chan

// ---- verification/steal_link_monitor.sv ----
// Assertions on the link between the multiplexor and its channels.
// Assumes the bench wires the interface signals in by name.
`timescale 1ns/1ps
module steal_link_monitor
   import cycle_steal_pkg::*;
#(
   parameter int NCH = NCH_DEF
) (
   input wire logic           CLK,
   input wire logic           RESET,
   input wire logic [3:0]     chan_time,
   input wire logic [NCH-1:0] demand,
   input wire logic [NCH-1:0] grant,
   input wire logic           buffer_time,
   input wire logic           retain_priority,
   input wire logic           indirect_follow_flag,
   input wire logic           sb_strobe
);
   // ********
   // Sequences
   // ********
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   sequence s_buf_start;
      $rose(buffer_time);
   endsequence
   sequence s_ind_start;
      $rose(retain_priority);
   endsequence
   // ********
   // Checks
   // ********
   chk_grant_single: assert property ($onehot0(grant))
      else $error("more than one channel granted");
   chk_set_at_nine: assert property (s_buf_start |->
      chan_time == T_SET && $past(demand) != '0)
      else $error("buffer time set off time nine");
   chk_grant_follows: assert property (s_buf_start |->
      ##[0:2] grant != '0) else $error("buffer cycle with no grant");
   chk_time_stands: assert property (s_buf_start |->
      buffer_time[*8]) else $error("buffer time dropped early");
   chk_strobe_pulse: assert property (sb_strobe |=> !sb_strobe)
      else $error("storage strobe longer than one cycle");
   chk_strobe_at_b7: assert property (sb_strobe |->
      buffer_time && chan_time == T_SAMPLE)
      else $error("storage strobe off its time");
   chk_retain_holds: assert property (retain_priority |-> buffer_time)
      else $error("retain without buffer time");
   chk_follow_after: assert property (s_ind_start |->
      ##[0:3] indirect_follow_flag) else $error("follow flag missing");
   chk_ctl_clear: assert property ($fell(retain_priority) |->
      chan_time == T_CTL_CLR) else $error("control cleared off time");
   chk_follow_clear: assert property ($fell(indirect_follow_flag) |->
      chan_time == T_FOLLOW_CLR) else $error("follow cleared off time");
   chk_one_level: assert property (s_ind_start |->
      !$past(indirect_follow_flag)) else $error("second indirect level");
endmodule : steal_link_monitor

// ---- verification/test_channel_memory_cycle_steal.sv ----
// Bench: multiplexor and one channel joined by the link.
// Assumes a small memory here; further channels are plain demand bits.
`timescale 1ns/1ps
module test_channel_memory_cycle_steal;
   import cycle_steal_pkg::*;
   logic                  clk, reset, i_req, e_req, o_req, stop, trap;
   logic                  store_busy, i_cyc, e_cyc, o_cyc, blocking, ovl;
   logic                  sel_e, sel_o, mem_wr, bt_seen, bt_prev;
   logic                  data_req, cmd_req, read_mode, data_done;
   logic [WORD_W-1:0]     rd_even, rd_odd, mem_wdata, wdata, data_reg;
   logic [WORD_W-1:0]     mem [0:31];
   logic [ADDR_W-2:0]     mem_addr;
   logic [NCH_DEF-1:0]    other_q, other_set;
   logic [OP_HI-OP_LO:0]  op_reg;
   logic [WC_HI-WC_LO:0]  wc;
   logic [ADDR_W-1:0]     addr_reg, loc;
   int                    fail_count, tests_run, sel_count, bt_fall;
   cycle_steal_if #(.NCH(NCH_DEF)) link ();
   steal_mux #(.NCH(NCH_DEF)) steal_mux_inst (.CLK(clk), .RESET(reset),
      .ch(link), .I_REQ(i_req), .E_REQ(e_req), .O_REQ(o_req),
      .MASTER_STOP(stop), .TRAP_BUSY(trap), .STORE_CHAN_BUSY(store_busy),
      .MEM_RDATA_EVEN(rd_even), .MEM_RDATA_ODD(rd_odd), .I_CYC(i_cyc),
      .E_CYC(e_cyc), .O_CYC(o_cyc), .BLOCKING(blocking),
      .OVERLAP_SUSPEND(ovl), .MEM_SEL_EVEN(sel_e), .MEM_SEL_ODD(sel_o),
      .MEM_WRITE(mem_wr), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata));
   steal_chan #(.NCH(NCH_DEF), .CH(0)) steal_chan_inst (.CLK(clk),
      .RESET(reset), .ch(link), .DATA_REQ(data_req), .CMD_REQ(cmd_req),
      .READ_MODE(read_mode), .CH_WDATA(wdata), .OTHER_DEMAND(other_q),
      .OP_REG(op_reg), .WORD_COUNT(wc), .ADDR_REG(addr_reg),
      .LOC_COUNT(loc), .DATA_REG(data_reg), .DATA_DONE(data_done));
   steal_link_monitor #(.NCH(NCH_DEF)) steal_link_monitor_inst (
      .CLK(clk), .RESET(reset), .chan_time(link.chan_time),
      .demand(link.demand), .grant(link.grant),
      .buffer_time(link.buffer_time),
      .retain_priority(link.retain_priority),
      .indirect_follow_flag(link.indirect_follow_flag),
      .sb_strobe(link.sb_strobe));
   // ********
   // Memory and watchers
   // ********
   // Unselected bus stays zero, as the mux ORs both buses together
   always @(posedge clk) begin
      other_q <= (other_q | other_set) & ~link.grant;
      bt_prev <= link.buffer_time;
      if (bt_prev && !link.buffer_time) bt_fall <= bt_fall + 1;
      if (link.buffer_time) bt_seen <= 1'b1;
      if (sel_e | sel_o) begin
         sel_count <= sel_count + 1;
         rd_even <= '0;
         rd_odd <= '0;
         if (mem_wr) mem[{mem_addr[3:0], sel_o}] <= mem_wdata;
         else if (sel_o) rd_odd <= mem[{mem_addr[3:0], 1'b1}];
         else rd_even <= mem[{mem_addr[3:0], 1'b0}];
      end
   end
   // ********
   // Helpers
   // ********
   function automatic logic [WORD_W-1:0] cw(input logic [2:0] op,
      input logic [14:0] cnt, input logic ind, input logic [14:0] a);
      cw = {op, cnt, ind, 2'b00, a};
   endfunction : cw
   task automatic chk(input logic [WORD_W-1:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   function automatic logic cond(input int k, input logic [14:0] v);
      case (k)
         0: cond = data_done;
         1: cond = loc == v;
         2: cond = link.buffer_time == v[0];
         3: cond = link.grant == v[3:0];
         default: cond = link.demand[0];
      endcase
   endfunction : cond
   // Bounded wait so that a stuck handshake ends in a mismatch
   task automatic await(input int k, input logic [14:0] v);
      int n;
      n = 0;
      while (cond(k, v) !== 1'b1 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      chk(n < 2000, 1'b1);
   endtask : await
   task automatic pulse(input bit cmd);
      @(posedge clk);
      if (cmd) cmd_req <= 1'b1;
      else data_req <= 1'b1;
      @(posedge clk);
      cmd_req <= 1'b0;
      data_req <= 1'b0;
   endtask : pulse
   // ********
   // Scenarios
   // ********
   task automatic sc_command;
      pulse(1);
      await(1, 15'h1);
      chk(op_reg, 3'h4);
      chk(wc, 15'h3);
      chk(addr_reg, 15'h5);
      await(0, 0);
      @(negedge clk);
      chk(data_reg, 36'h9_8765_4321);
      chk(link.store_trig, 1'b0);
   endtask : sc_command
   task automatic sc_indirect;
      int s0;
      s0 = sel_count;
      pulse(1);
      await(1, 15'h2);
      chk(op_reg, 3'h2);
      chk(wc, 15'h7);
      chk(addr_reg, 15'h7);
      chk(WORD_W'(sel_count - s0), 36'h2);
   endtask : sc_indirect
   task automatic sc_block;
      int s0;
      @(posedge clk);
      {i_req, e_req, o_req} <= 3'h7;
      read_mode <= 1'b1;
      wdata <= 36'h5_a5a5_0f0f;
      // The last indirect cycle may still hold buffer time here
      await(2, 15'h0);
      repeat (12) @(negedge clk);
      chk({i_cyc, e_cyc, o_cyc}, 3'h7);
      s0 = sel_count;
      pulse(0);
      await(2, 15'h1);
      repeat (12) @(negedge clk);
      chk({blocking, ovl, i_cyc, e_cyc, o_cyc}, 5'h18);
      chk(link.store_trig, 1'b1);
      await(0, 0);
      chk(mem[7], 36'h5_a5a5_0f0f);
      chk(WORD_W'(sel_count - s0), 36'h1);
      await(2, 15'h0);
      repeat (18) @(negedge clk);
      chk({blocking, i_cyc, e_cyc, o_cyc}, 4'h7);
      @(posedge clk);
      stop <= 1'b1;
      repeat (3) @(negedge clk);
      chk({blocking, i_cyc}, 2'h2);
      @(posedge clk);
      stop <= 1'b0;
      {i_req, e_req, o_req} <= 3'h0;
   endtask : sc_block
   task automatic sc_hold;
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         trap <= (k == 0);
         store_busy <= (k == 1);
         read_mode <= 1'b0;
         await(2, 15'h0);
         bt_seen = 1'b0;
         pulse(0);
         repeat (450) @(negedge clk);
         chk(bt_seen, 1'b0);
         @(posedge clk);
         trap <= 1'b0;
         store_busy <= 1'b0;
         await(0, 0);
      end
   endtask : sc_hold
   task automatic sc_priority;
      int f0;
      pulse(0);
      await(4, 0);
      @(posedge clk);
      other_set <= 4'h6;
      @(posedge clk);
      other_set <= 4'h0;
      await(3, 15'h1);
      f0 = bt_fall;
      await(3, 15'h2);
      await(3, 15'h4);
      chk(WORD_W'(bt_fall - f0), 36'h0);
   endtask : sc_priority
   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : give_verdict
   // ********
   // Run
   // ********
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      reset = 1'b1;
      {i_req, e_req, o_req, stop, trap, store_busy} = '0;
      {data_req, cmd_req, read_mode, bt_seen, bt_prev} = '0;
      {rd_even, rd_odd, wdata, other_q, other_set} = '0;
      {fail_count, tests_run, sel_count, bt_fall} = '0;
      for (int i = 0; i < 32; i++) mem[i] = '0;
      mem[0] = cw(3'h4, 15'h3, 1'b0, 15'h5);
      mem[1] = cw(3'h2, 15'h7, 1'b1, 15'h4);
      mem[4] = cw(3'h5, 15'h1, 1'b1, 15'h7);
      mem[5] = 36'h9_8765_4321;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
      sc_command();
      sc_indirect();
      sc_block();
      sc_hold();
      sc_priority();
      give_verdict();
   end
   // Run needs some 3800 cycles; the margin is wide
   initial begin
      repeat (40000) @(posedge clk);
      fail_count++;
      give_verdict();
   end
endmodule : test_channel_memory_cycle_steal
